// ### src/tfa_terminal_assign.sv
`timescale 1ns/100ps
// Behaviour
// - Link enable gives link commands priority
// - Unassigned link enable counts as active
// - Universal inputs only monitored, never drive
// - Speed search choice sampled at run start
// - Forced stop decelerates, then raises alarm
// - Local select moves run/frequency to keypad
// - Dew input heats halted motor
// - Set select switches run commands to the second forward/reverse pair
// - Second forward/reverse run, release stops
// - Forward input runs forward, release stops
// - Reverse input runs reverse, release stops
// - Forward/reverse only via dedicated run terminals
// - Each output code selects signal, polarity
// - Code plus 1000 inverts same signal
// - Switchover codes 11-13 refuse inversion
// - Alarm relay energises on alarm, normal logic
// - Codes 54, 55 give remote, run-active flags
// - Code 99/1099 routes any alarm
// - Running flag hysteresis on start/stop frequency
module tfa_terminal_assign #(
    parameter int unsigned GEN_TERMS = tfa_pkg::TFA_GEN_TERMS,
    parameter int unsigned OUT_NUM = tfa_pkg::TFA_OUT_NUM
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Terminal pins: general terminals then the two dedicated run terminals
    input wire logic [GEN_TERMS-1:0] gen_term_pin_i,
    input wire logic [1:0] run_term_pin_i,
    input wire logic [tfa_pkg::TFA_IN_CODE_W-1:0] gen_term_func_i [GEN_TERMS],
    input wire logic [tfa_pkg::TFA_IN_CODE_W-1:0] run_terminal_assign_a_i,
    input wire logic [tfa_pkg::TFA_IN_CODE_W-1:0] run_terminal_assign_b_i,
    // Source configuration
    input wire logic [1:0] run_source_config_i,
    input wire logic [1:0] serial_link_function_i,
    input wire logic [1:0] fieldbus_link_function_i,
    input wire logic [15:0] link_run_word_i,
    input wire tfa_pkg::tfa_run_t keypad_run_i,
    input wire logic [15:0] forced_stop_decel_time_i,
    input wire logic alarm_reset_i,
    // Drive core status
    input wire logic motor_stopped_i,
    input wire logic dc_brake_active_i,
    input wire logic drive_alarm_i,
    input wire logic [tfa_pkg::TFA_FREQ_W-1:0] out_freq_i,
    input wire logic [tfa_pkg::TFA_FREQ_W-1:0] start_freq_i,
    input wire logic [tfa_pkg::TFA_FREQ_W-1:0] stop_freq_i,
    input wire logic [tfa_pkg::TFA_SIG_NUM-1:0] drive_sig_i,
    // Programmable outputs
    input wire logic [tfa_pkg::TFA_OUT_CODE_W-1:0] out_func_i [OUT_NUM],
    output logic [OUT_NUM-1:0] out_pin_o,
    output logic [OUT_NUM-1:0] out_code_reject_o,
    // Commands to the drive core
    output tfa_pkg::tfa_run_t run_cmd_o,
    output tfa_pkg::tfa_src_t run_src_o,
    output tfa_pkg::tfa_src_t freq_src_o,
    output logic speed_search_o,
    output logic forced_decel_o,
    output logic [15:0] decel_time_o,
    output logic dew_heat_o,
    output logic [7:0] alarm_code_o,
    output logic [GEN_TERMS+1:0] universal_monitor_o,
    output logic [GEN_TERMS+1:0] assign_reject_o
);
    import tfa_pkg::*;

    localparam int unsigned NT = GEN_TERMS + 2;
    localparam int unsigned NF = 11;

    // ---
    // Terminal synchronisers
    // ---
    logic [NT-1:0] pin_meta;
    logic [NT-1:0] pin_sync;

    // Pins come from outside; only pin_sync is read by logic
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {run_term_pin_i, gen_term_pin_i};
            pin_sync <= pin_meta;
        end
    end

    // ---
    // Per-terminal function decode
    // ---
    wire logic [TFA_IN_CODE_W-1:0] term_func [NT];
    wire logic [NF-1:0] term_hit [NT];
    wire logic [NT-1:0] term_reject;
    logic [NF-1:0] fn_assigned;
    logic [NF-1:0] fn_level;

    // Function slots, in the order of the hit vector
    localparam logic [TFA_IN_CODE_W-1:0] FN_CODE [NF] = '{
        IN_LINK_ENABLE, IN_UNIV_MONITOR, IN_SPEED_SEARCH, IN_FORCED_STOP,
        IN_LOCAL_SEL, IN_DEW_HEAT, IN_SET_SELECT, IN_SECOND_FORWARD_RUN, IN_SECOND_REVERSE_RUN,
        IN_FWD, IN_REV
    };
    localparam int unsigned F_LE = 0;
    localparam int unsigned F_UM = 1;
    localparam int unsigned F_SS = 2;
    localparam int unsigned F_STOP = 3;
    localparam int unsigned F_LOC = 4;
    localparam int unsigned F_DEW = 5;
    localparam int unsigned F_SET = 6;
    localparam int unsigned F_SECOND_FORWARD_RUN = 7;
    localparam int unsigned F_SECOND_REVERSE_RUN = 8;
    localparam int unsigned F_FWD = 9;
    localparam int unsigned F_REV = 10;

    genvar t;
    genvar f;
    generate
        for (t = 0; t < NT; t++) begin : g_term
            wire logic is_run_code;
            wire logic dedicated;
            if (t < GEN_TERMS) begin : g_gen
                assign term_func[t] = gen_term_func_i[t];
            end else if (t == GEN_TERMS) begin : g_run_a
                assign term_func[t] = run_terminal_assign_a_i;
            end else begin : g_run_b
                assign term_func[t] = run_terminal_assign_b_i;
            end
            assign dedicated = (t >= GEN_TERMS);
            assign is_run_code = (term_func[t] == IN_FWD) || (term_func[t] == IN_REV);
            // Run codes on a general terminal are refused and do nothing
            assign term_reject[t] = is_run_code && !dedicated;
            for (f = 0; f < NF; f++) begin : g_fn
                assign term_hit[t][f] = (term_func[t] == FN_CODE[f]) && !term_reject[t];
            end
            // Universal inputs go to the monitor port only
            assign universal_monitor_o[t] = term_hit[t][F_UM] && pin_sync[t];
        end
    endgenerate

    // Combine terminals: a function is on if any terminal holding it is on
    always_comb begin
        fn_assigned = '0;
        fn_level = '0;
        for (int i = 0; i < NT; i++) begin
            fn_assigned = fn_assigned | term_hit[i];
            fn_level = fn_level | (term_hit[i] & {NF{pin_sync[i]}});
        end
    end

    assign assign_reject_o = term_reject;

    // ---
    // Effective command levels
    // ---
    wire logic link_enable_cmd;
    wire logic local_keypad_select;
    wire logic run_source_set_select;
    wire logic forced_stop_req;
    wire logic link_run_en;
    wire logic link_freq_en;
    wire tfa_run_t forward_pair;
    wire tfa_run_t second_pair;
    wire tfa_run_t link_pair;
    wire tfa_run_t link_pair2;
    wire tfa_run_t cfg_pair;

    // Without a terminal holding it, link enable behaves as always on
    assign link_enable_cmd = fn_assigned[F_LE] ? fn_level[F_LE] : 1'b1;
    assign local_keypad_select = fn_level[F_LOC];
    assign run_source_set_select = fn_level[F_SET];
    // Forced stop is a fail-safe input: acting when its terminal goes off
    assign forced_stop_req = fn_assigned[F_STOP] && !fn_level[F_STOP];
    assign link_run_en = link_enable_cmd
        && (serial_link_function_i[LF_RUN] || fieldbus_link_function_i[LF_RUN]);
    assign link_freq_en = link_enable_cmd
        && (serial_link_function_i[LF_FREQ] || fieldbus_link_function_i[LF_FREQ]);

    // Run pairs from each possible source
    assign forward_pair = '{forward_run: fn_level[F_FWD], reverse_run: fn_level[F_REV]};
    assign second_pair = '{forward_run: fn_level[F_SECOND_FORWARD_RUN], reverse_run: fn_level[F_SECOND_REVERSE_RUN]};
    assign link_pair = '{forward_run: link_run_word_i[LW_FWD], reverse_run: link_run_word_i[LW_REV]};
    assign link_pair2 = '{forward_run: link_run_word_i[LW_SECOND_FORWARD_RUN], reverse_run: link_run_word_i[LW_SECOND_REVERSE_RUN]};
    assign cfg_pair = (run_source_config_i == RUNCFG_TERMINAL) ? forward_pair : keypad_run_i;

    // ---
    // Source selection
    // ---
    tfa_run_t sel_pair;
    tfa_src_t next_run_src;
    tfa_src_t next_freq_src;

    // Local wins over link, link over terminals
    always_comb begin
        if (local_keypad_select) begin
            sel_pair = keypad_run_i;
            next_run_src = SRC_KEYPAD;
        end else if (link_run_en) begin
            sel_pair = run_source_set_select ? link_pair2 : link_pair;
            next_run_src = SRC_LINK;
        end else if (run_source_set_select) begin
            sel_pair = second_pair;
            next_run_src = SRC_TERMINAL;
        end else begin
            sel_pair = cfg_pair;
            next_run_src = (run_source_config_i == RUNCFG_TERMINAL) ? SRC_TERMINAL
                : SRC_KEYPAD;
        end
    end

    // Frequency follows the same local and link priorities
    always_comb begin
        if (local_keypad_select) begin
            next_freq_src = SRC_KEYPAD;
        end else if (link_freq_en) begin
            next_freq_src = SRC_LINK;
        end else begin
            next_freq_src = SRC_TERMINAL;
        end
    end

    // ---
    // Forced stop sequence
    // ---
    tfa_fs_state_t fs_state;
    tfa_fs_state_t next_fs_state;

    always_comb begin
        case (fs_state)
            FS_IDLE: begin
                next_fs_state = forced_stop_req ? FS_DECEL : FS_IDLE;
            end
            FS_DECEL: begin
                // Alarm is only raised once the motor has really stopped
                next_fs_state = motor_stopped_i ? FS_ALARM : FS_DECEL;
            end
            FS_ALARM: begin
                next_fs_state = alarm_reset_i ? FS_IDLE : FS_ALARM;
            end
            default: begin
                next_fs_state = FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            fs_state <= FS_IDLE;
        end else begin
            fs_state <= next_fs_state;
        end
    end

    // ---
    // Run command and its side effects
    // ---
    wire logic run_blocked;
    wire logic run_request;
    wire tfa_run_t next_run;
    wire logic run_start;
    wire logic any_alarm;
    wire logic [7:0] next_alarm_code;
    logic running_flag;
    logic next_running;

    // Both directions at once is treated as stop, not as a guess
    assign run_blocked = (fs_state != FS_IDLE) || forced_stop_req || drive_alarm_i;
    assign run_request = (sel_pair.forward_run ^ sel_pair.reverse_run) && !run_blocked;
    // Releasing the run input simply drops the request; the core decelerates
    assign next_run = run_request ? sel_pair : '{forward_run: 1'b0, reverse_run: 1'b0};
    assign run_start = run_request && !(run_cmd_o.forward_run || run_cmd_o.reverse_run);
    assign any_alarm = drive_alarm_i || (fs_state == FS_ALARM);
    assign next_alarm_code = (fs_state == FS_ALARM) ? ALARM_FORCED_STOP : ALARM_NONE;

    // Running flag holds between the stop and start thresholds
    always_comb begin
        if (dc_brake_active_i) begin
            next_running = 1'b0;
        end else if (out_freq_i > start_freq_i) begin
            next_running = 1'b1;
        end else if (out_freq_i < stop_freq_i) begin
            next_running = 1'b0;
        end else begin
            next_running = running_flag;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            run_cmd_o <= '{forward_run: 1'b0, reverse_run: 1'b0};
            run_src_o <= SRC_KEYPAD;
            freq_src_o <= SRC_KEYPAD;
            running_flag <= 1'b0;
            alarm_code_o <= ALARM_NONE;
        end else begin
            run_cmd_o <= next_run;
            run_src_o <= next_run_src;
            freq_src_o <= next_freq_src;
            running_flag <= next_running;
            alarm_code_o <= next_alarm_code;
        end
    end

    // Search choice is caught only on the start edge and held until the run request drops
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            speed_search_o <= 1'b0;
        end else if (run_start) begin
            speed_search_o <= fn_level[F_SS];
        end else if (!run_request) begin
            speed_search_o <= 1'b0;
        end
    end

    // Deceleration flag and heating follow the sequence and the halt state; the time is copied every cycle
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            forced_decel_o <= 1'b0;
            decel_time_o <= '0;
            dew_heat_o <= 1'b0;
        end else begin
            forced_decel_o <= (next_fs_state == FS_DECEL);
            decel_time_o <= forced_stop_decel_time_i;
            // Heating never fights a run request on a turning motor
            dew_heat_o <= fn_level[F_DEW] && motor_stopped_i && !run_request;
        end
    end

    // ---
    // Output signal table and terminal mapping
    // ---
    logic [TFA_SIG_NUM-1:0] sig_vec;

    // Internal flags replace the core's bits at their own codes
    always_comb begin
        sig_vec = drive_sig_i;
        sig_vec[OUT_RUNNING] = running_flag;
        sig_vec[OUT_REMOTE] = !local_keypad_select;
        sig_vec[OUT_RUN_ACTIVE] = run_cmd_o.forward_run || run_cmd_o.reverse_run;
        sig_vec[OUT_ANY_ALARM] = any_alarm;
    end

    genvar o;
    generate
        for (o = 0; o < OUT_NUM; o++) begin : g_out
            tfa_out_map u_map (
                .mclk_i(mclk_i),
                .rst_b_i(rst_b_i),
                .code_i(out_func_i[o]),
                .sig_i(sig_vec),
                .level_o(out_pin_o[o]),
                .reject_o(out_code_reject_o[o])
            );
        end
    endgenerate

endmodule

// ### pkg/tfa_pkg.sv
package tfa_pkg;

    // ---
    // Sizes
    // ---
    localparam int unsigned TFA_GEN_TERMS = 5;
    localparam int unsigned TFA_OUT_NUM = 5;
    localparam int unsigned TFA_IN_CODE_W = 8;
    localparam int unsigned TFA_OUT_CODE_W = 11;
    localparam int unsigned TFA_SIG_NUM = 100;
    localparam int unsigned TFA_FREQ_W = 16;

    // ---
    // Input function codes
    // ---
    localparam logic [7:0] IN_LINK_ENABLE = 8'h18;   // 24
    localparam logic [7:0] IN_UNIV_MONITOR = 8'h19;  // 25
    localparam logic [7:0] IN_SPEED_SEARCH = 8'h1A;  // 26
    localparam logic [7:0] IN_FORCED_STOP = 8'h1E;   // 30
    localparam logic [7:0] IN_LOCAL_SEL = 8'h23;     // 35
    localparam logic [7:0] IN_DEW_HEAT = 8'h27;      // 39
    localparam logic [7:0] IN_SET_SELECT = 8'h57;    // 87
    localparam logic [7:0] IN_SECOND_FORWARD_RUN = 8'h58;          // 88
    localparam logic [7:0] IN_SECOND_REVERSE_RUN = 8'h59;          // 89
    localparam logic [7:0] IN_FWD = 8'h62;           // 98
    localparam logic [7:0] IN_REV = 8'h63;           // 99

    // ---
    // Output function codes
    // ---
    localparam logic [10:0] OUT_INV_OFFSET = 11'h3E8;  // 1000
    localparam logic [10:0] OUT_INV_LIMIT = 11'h44C;   // 1100
    localparam logic [6:0] OUT_RUNNING = 7'h00;        // 0
    localparam logic [6:0] OUT_AUTO_RESTART = 7'h06;   // 6
    localparam logic [6:0] OUT_LINE_CONTACTOR = 7'h0B; // 11
    localparam logic [6:0] OUT_SECONDARY_CONT = 7'h0D; // 13
    localparam logic [6:0] OUT_REMOTE = 7'h36;         // 54
    localparam logic [6:0] OUT_RUN_ACTIVE = 7'h37;     // 55
    localparam logic [6:0] OUT_ANY_ALARM = 7'h63;      // 99

    // ---
    // Link word bits and configuration fields
    // ---
    localparam int unsigned LW_FWD = 0;
    localparam int unsigned LW_REV = 1;
    localparam int unsigned LW_SECOND_FORWARD_RUN = 2;
    localparam int unsigned LW_SECOND_REVERSE_RUN = 3;
    localparam int unsigned LF_FREQ = 0;
    localparam int unsigned LF_RUN = 1;
    localparam logic [1:0] RUNCFG_TERMINAL = 2'h1;
    localparam logic [7:0] ALARM_NONE = 8'h00;
    localparam logic [7:0] ALARM_FORCED_STOP = 8'h01;

    // ---
    // Types
    // ---
    typedef struct packed {
        logic forward_run;
        logic reverse_run;
    } tfa_run_t;

    typedef enum logic [2:0] {
        SRC_KEYPAD = 3'b001,
        SRC_TERMINAL = 3'b010,
        SRC_LINK = 3'b100
    } tfa_src_t;

    typedef enum logic [2:0] {
        FS_IDLE = 3'b001,
        FS_DECEL = 3'b010,
        FS_ALARM = 3'b100
    } tfa_fs_state_t;

endpackage

// ### src/tfa_out_map.sv
`timescale 1ns/100ps
module tfa_out_map (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [tfa_pkg::TFA_OUT_CODE_W-1:0] code_i,
    input wire logic [tfa_pkg::TFA_SIG_NUM-1:0] sig_i,
    output logic level_o,
    output logic reject_o
);
    import tfa_pkg::*;

    // ---
    // Code decode
    // ---
    wire logic is_inv;
    wire logic is_norm;
    wire logic [10:0] sel_full;
    wire logic [6:0] sel;
    wire logic no_inv_code;
    wire logic code_ok;
    wire logic next_level;

    // Codes 1000..1099 name the same signal as code minus 1000, inverted
    assign is_inv = (code_i >= OUT_INV_OFFSET) && (code_i < OUT_INV_LIMIT);
    assign is_norm = code_i < 11'(TFA_SIG_NUM);
    assign sel_full = is_inv ? (code_i - OUT_INV_OFFSET) : code_i;
    assign sel = sel_full[6:0];
    // Source switchover signals have no inverted form
    assign no_inv_code = (sel >= OUT_LINE_CONTACTOR) && (sel <= OUT_SECONDARY_CONT);
    assign code_ok = is_norm || (is_inv && !no_inv_code);
    // A refused code leaves the terminal off rather than guessing a polarity
    assign next_level = code_ok && (sig_i[sel] ^ is_inv);

    // Registered level; off (relay de-energised) from reset
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            level_o <= 1'b0;
            reject_o <= 1'b0;
        end else begin
            level_o <= next_level;
            reject_o <= !code_ok;
        end
    end

endmodule

// ### dv/tfa_partner.sv
`timescale 1ns/100ps
module tfa_partner #(
    parameter int unsigned MASK_CYCLES = 32
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] gen_req_i,
    input wire logic [1:0] run_req_i,
    input wire logic [4:0] out_pin_i,
    input wire logic [4:0] out_neg_i,
    output logic [4:0] gen_term_pin_o,
    output logic [1:0] run_term_pin_o,
    output logic [4:0] out_active_o
);
    // ---
    // Terminal drive and output readback
    // ---
    logic [7:0] since_on;
    // Contacts move on the edge, one controller scan
    always_ff @(posedge mclk_i) begin
        gen_term_pin_o <= gen_req_i;
        run_term_pin_o <= run_req_i;
        if (!rst_b_i) begin
            since_on <= 8'h00;
        end else if (since_on < MASK_CYCLES) begin
            since_on <= since_on + 8'h01;
        end
    end
    // Untrusted after power-on: negative-logic outputs read active
    assign out_active_o = (since_on < MASK_CYCLES) ? out_neg_i : (out_pin_i ^ out_neg_i);
endmodule

// ### dv/tfa_terminal_assign_asserts.sv
`timescale 1ns/100ps
module tfa_terminal_assign_asserts #(
    parameter int unsigned GEN_TERMS = tfa_pkg::TFA_GEN_TERMS,
    parameter int unsigned OUT_NUM = tfa_pkg::TFA_OUT_NUM
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [tfa_pkg::TFA_IN_CODE_W-1:0] gen_term_func_i [GEN_TERMS],
    input wire logic [15:0] forced_stop_decel_time_i,
    input wire logic motor_stopped_i,
    input wire logic [tfa_pkg::TFA_SIG_NUM-1:0] drive_sig_i,
    input wire logic [tfa_pkg::TFA_OUT_CODE_W-1:0] out_func_i [OUT_NUM],
    input wire logic [OUT_NUM-1:0] out_pin_o,
    input wire logic [OUT_NUM-1:0] out_code_reject_o,
    input wire tfa_pkg::tfa_run_t run_cmd_o,
    input wire logic dew_heat_o,
    input wire logic [15:0] decel_time_o,
    input wire logic forced_decel_o,
    input wire logic [7:0] alarm_code_o,
    input wire logic [GEN_TERMS+1:0] assign_reject_o
);
    import tfa_pkg::*;
    // ---
    // Port relations
    // ---
    logic [GEN_TERMS-1:0] run_code_here;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Refusal is combinational
    for (genvar i = 0; i < GEN_TERMS; i++) begin : g_run_code
        assign run_code_here[i] = gen_term_func_i[i] inside {IN_FWD, IN_REV};
    end
    a_run_code_reject: assert property (assign_reject_o[GEN_TERMS-1:0] == run_code_here)
        else $error("run code not refused");
    a_switch_inv_refused: assert property (out_func_i[1] inside {[11'h3F3:11'h3F5]}
        |=> out_code_reject_o[1] && !out_pin_o[1])
        else $error("inverted switchover code accepted");
    a_inverted_level: assert property (out_func_i[1] == 11'h3EE
        |=> out_pin_o[1] == !$past(drive_sig_i[6]))
        else $error("no inversion");
    a_normal_level: assert property (out_func_i[1] == 11'h006
        |=> out_pin_o[1] == $past(drive_sig_i[6]))
        else $error("normal code mismatch");
    // Only once alarm and code have settled
    a_alarm_relay_on: assert property (
        alarm_code_o == ALARM_FORCED_STOP && $past(alarm_code_o) == ALARM_FORCED_STOP
        && out_func_i[4] == 11'h063 && $stable(out_func_i[4]) |-> out_pin_o[4])
        else $error("alarm relay off");
    a_dir_exclusive: assert property (!(run_cmd_o.forward_run && run_cmd_o.reverse_run))
        else $error("both directions commanded");
    a_stop_blocks_run: assert property (forced_decel_o
        |-> run_cmd_o == 2'b00 && decel_time_o == $past(forced_stop_decel_time_i))
        else $error("forced stop run or time");
    a_dew_when_halted: assert property (dew_heat_o
        |-> $past(motor_stopped_i) && run_cmd_o == 2'b00)
        else $error("dew heat while turning");
endmodule

bind tfa_terminal_assign tfa_terminal_assign_asserts #(.GEN_TERMS(GEN_TERMS), .OUT_NUM(OUT_NUM))
    u_tfa_chk (.*);

// ### dv/tfa_terminal_assign_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("BAD %s expected %0h seen %0h", n, e, g); \
    end \
end
module tfa_terminal_assign_bench;
    import tfa_pkg::*;
    // ---
    // Signals and instances
    // ---
    logic mclk_i = 1'b0, rst_b_i = 1'b0, alarm_reset_i = 1'b0, motor_stopped_i = 1'b0;
    logic dc_brake_active_i = 1'b0, drive_alarm_i = 1'b0, speed_search_o, forced_decel_o;
    logic dew_heat_o;
    logic [4:0] gpin = 5'h00, gen_term_pin_i, out_pin_o, out_code_reject_o, pact;
    logic [1:0] rpin = 2'h0, run_term_pin_i, run_source_config_i = RUNCFG_TERMINAL;
    logic [1:0] serial_link_function_i = 2'h0, fieldbus_link_function_i = 2'h0;
    logic [7:0] run_terminal_assign_a_i = IN_FWD, run_terminal_assign_b_i = IN_REV;
    logic [7:0] alarm_code_o;
    logic [7:0] gen_term_func_i [5] = '{default: 8'h00};
    logic [15:0] link_run_word_i = 16'h0000, forced_stop_decel_time_i = 16'h1234;
    logic [15:0] out_freq_i = 16'h0000, start_freq_i = 16'h000A, stop_freq_i = 16'h0005;
    logic [15:0] decel_time_o;
    logic [99:0] drive_sig_i = 100'h840;
    logic [10:0] out_func_i [5] = '{default: 11'h000};
    logic [6:0] universal_monitor_o, assign_reject_o;
    tfa_run_t keypad_run_i = 2'b00, run_cmd_o;
    tfa_src_t run_src_o, freq_src_o;
    int fail_count = 0, checks_done = 0, cycles = 0;
    tfa_partner u_tfa_partner (.mclk_i, .rst_b_i, .gen_req_i(gpin), .run_req_i(rpin),
        .out_pin_i(out_pin_o), .out_neg_i(5'h18), .gen_term_pin_o(gen_term_pin_i),
        .run_term_pin_o(run_term_pin_i), .out_active_o(pact));
    tfa_terminal_assign u_tfa_terminal_assign (.*);
    // Clock and hang guard
    always #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict;
        end
    end
    // ---
    // Shared steps
    // ---
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Partner, sync chain, output register
    task automatic settle;
        repeat (7) @(posedge mclk_i);
        #1;
    endtask
    task automatic go(input logic [4:0] g, input logic [1:0] r);
        @(posedge mclk_i);
        gpin <= g;
        rpin <= r;
        settle;
    endtask
    task automatic clr;
        @(posedge mclk_i);
        gen_term_func_i <= '{default: 8'h00};
        serial_link_function_i <= 2'h0;
        go(5'h00, 2'h0);
    endtask
    task automatic t_run_terms;
        @(posedge mclk_i);
        out_func_i[0] <= 11'h037;
        go(5'h00, 2'h1);
        `CHK("fwd run", 2'b10, run_cmd_o)
        `CHK("run source", SRC_TERMINAL, run_src_o)
        `CHK("run active flag", 1'b1, out_pin_o[0])
        go(5'h00, 2'h3);
        `CHK("both directions", 2'b00, run_cmd_o)
        go(5'h00, 2'h2);
        `CHK("rev run", 2'b01, run_cmd_o)
        go(5'h00, 2'h0);
        `CHK("released", 2'b00, run_cmd_o)
    endtask
    task automatic t_link;
        @(posedge mclk_i);
        gen_term_func_i[0] <= IN_SET_SELECT;
        serial_link_function_i <= 2'h3;
        link_run_word_i <= 16'h0001;
        go(5'h00, 2'h0);
        `CHK("link fwd", 2'b10, run_cmd_o)
        `CHK("link run src", SRC_LINK, run_src_o)
        `CHK("link freq src", SRC_LINK, freq_src_o)
        @(posedge mclk_i);
        link_run_word_i <= 16'h0009;
        go(5'h01, 2'h0);
        `CHK("link second_reverse_run", 2'b01, run_cmd_o)
        @(posedge mclk_i);
        gen_term_func_i[1] <= IN_LINK_ENABLE;
        gen_term_func_i[2] <= IN_SECOND_FORWARD_RUN;
        go(5'h05, 2'h0);
        `CHK("second fwd", 2'b10, run_cmd_o)
        `CHK("terminal src", SRC_TERMINAL, run_src_o)
        go(5'h01, 2'h0);
        `CHK("second released", 2'b00, run_cmd_o)
        go(5'h04, 2'h2);
        `CHK("set one rev", 2'b01, run_cmd_o)
    endtask
    task automatic t_local;
        @(posedge mclk_i);
        gen_term_func_i[3] <= IN_LOCAL_SEL;
        serial_link_function_i <= 2'h3;
        keypad_run_i <= 2'b01;
        out_func_i[0] <= 11'h036;
        go(5'h08, 2'h0);
        `CHK("keypad run", 2'b01, run_cmd_o)
        `CHK("keypad run src", SRC_KEYPAD, run_src_o)
        `CHK("keypad freq src", SRC_KEYPAD, freq_src_o)
        `CHK("remote flag off", 1'b0, out_pin_o[0])
        @(posedge mclk_i);
        keypad_run_i <= 2'b00;
        go(5'h00, 2'h0);
        `CHK("remote flag on", 1'b1, out_pin_o[0])
        `CHK("back to link", SRC_LINK, run_src_o)
    endtask
    // Stop pin is ON before assignment: no early stop
    task automatic t_forced_stop;
        @(posedge mclk_i);
        out_func_i[4] <= 11'h063;
        out_func_i[3] <= 11'h44B;
        go(5'h10, 2'h1);
        @(posedge mclk_i);
        gen_term_func_i[4] <= IN_FORCED_STOP;
        settle;
        `CHK("run before stop", 2'b10, run_cmd_o)
        go(5'h00, 2'h1);
        `CHK("decelerating", 1'b1, forced_decel_o)
        `CHK("run dropped", 2'b00, run_cmd_o)
        `CHK("decel time", forced_stop_decel_time_i, decel_time_o)
        @(posedge mclk_i);
        motor_stopped_i <= 1'b1;
        settle;
        `CHK("stop alarm", ALARM_FORCED_STOP, alarm_code_o)
        `CHK("relay energised", 1'b1, out_pin_o[4])
        `CHK("inverted alarm", 1'b0, out_pin_o[3])
        @(posedge mclk_i);
        alarm_reset_i <= 1'b1;
        go(5'h10, 2'h0);
        `CHK("alarm cleared", ALARM_NONE, alarm_code_o)
        `CHK("relay released", 1'b0, out_pin_o[4])
        @(posedge mclk_i);
        alarm_reset_i <= 1'b0;
        motor_stopped_i <= 1'b0;
    endtask
    task automatic t_dew_search;
        @(posedge mclk_i);
        gen_term_func_i[0] <= IN_DEW_HEAT;
        gen_term_func_i[1] <= IN_SPEED_SEARCH;
        gen_term_func_i[2] <= IN_UNIV_MONITOR;
        gen_term_func_i[3] <= IN_FWD;
        motor_stopped_i <= 1'b1;
        go(5'h0F, 2'h0);
        `CHK("dew heat", 1'b1, dew_heat_o)
        `CHK("monitor bit", 1'b1, universal_monitor_o[2])
        `CHK("no run", 2'b00, run_cmd_o)
        `CHK("run code refused", 7'h08, assign_reject_o)
        @(posedge mclk_i);
        motor_stopped_i <= 1'b0;
        go(5'h07, 2'h1);
        `CHK("speed search", 1'b1, speed_search_o)
        `CHK("dew off running", 1'b0, dew_heat_o)
    endtask
    task automatic t_out_codes;
        logic [10:0] oc [5] = '{11'h006, 11'h3EE, 11'h00B, 11'h3F3, 11'h44C};
        logic [15:0] fq [4] = '{16'h0014, 16'h0007, 16'h0003, 16'h0014};
        logic [4:0] ep = 5'h05, er = 5'h18;
        logic [3:0] rn = 4'h3;
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_i);
            out_func_i[1] <= oc[i];
            settle;
            `CHK("code level", ep[i], out_pin_o[1])
            `CHK("code reject", er[i], out_code_reject_o[1])
        end
        // Second step is between thresholds: flag holds
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            out_freq_i <= fq[i];
            dc_brake_active_i <= (i == 3);
            settle;
            `CHK("running flag", rn[i], out_pin_o[2])
        end
    endtask
    // ---
    // Main sequence
    // ---
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        settle;
        `CHK("masked outputs", 5'h18, pact)
        t_run_terms;
        t_link;
        clr;
        t_local;
        clr;
        t_forced_stop;
        clr;
        t_dew_search;
        clr;
        t_out_codes;
        print_verdict;
    end
endmodule
